// file: include/rxcfg_map.svh
// Constants for the receiver configuration loader: field positions, reset values, timing.
// Assumes inclusion by bare name from the package only.
`ifndef RXCFG_MAP_SVH
`define RXCFG_MAP_SVH

`define RXCFG_WORD_W        20
`define RXCFG_BIT_AGC_FAST  19
`define RXCFG_BIT_WDOG_OFF  18
`define RXCFG_BIT_SQUELCH   17
`define RXCFG_BIT_POLL      15
`define RXCFG_SLEEP_HI      14
`define RXCFG_SLEEP_LO      12
`define RXCFG_WIN_HI        11
`define RXCFG_WIN_LO        9
`define RXCFG_VALID_HI      8
`define RXCFG_VALID_LO      7
`define RXCFG_SLICE_HI      6
`define RXCFG_SLICE_LO      5
`define RXCFG_BW_HI         4
`define RXCFG_BW_LO         3
// Power-on word: poll off, sleep 010, window 111, valid 00, slice 11, bandwidth 11
`define RXCFG_RESET_WORD    20'h4_2_E_7_8
// Least serial clock rate while loading, and the idle timeout it implies
`define RXCFG_SCLK_MIN_HZ   5000
`define RXCFG_CLK_HZ        250000000
`define RXCFG_IDLE_CYCLES   (`RXCFG_CLK_HZ / `RXCFG_SCLK_MIN_HZ)
// Sleep base unit (10 ms) in system clock cycles, shifted by the sleep code
`define RXCFG_SLEEP_BASE_MS 10
`define RXCFG_SLEEP_BASE_CY (`RXCFG_CLK_HZ / 1000 * `RXCFG_SLEEP_BASE_MS)
// Wake-up bit checking window base unit, in microseconds
`define RXCFG_WIN_BASE_US   38

`endif

// file: include/rxcfg_pkg.sv
// Types for the receiver configuration loader.
// Assumes rxcfg_map.svh is on the include path.
package rxcfg_pkg;
  `include "rxcfg_map.svh"
  typedef logic [`RXCFG_WORD_W-1:0] rxcfg_word_t;
  typedef enum logic [1:0] {RXCFG_IDLE, RXCFG_ARMED, RXCFG_SHIFT} rxcfg_link_e;
  typedef enum logic [1:0] {RXCFG_AWAKE, RXCFG_SLEEP, RXCFG_CHECK, RXCFG_RUN} rxcfg_poll_e;
endpackage

// file: rtl/rxcfg_sync.sv
// Two-flop level synchroniser into the system clock domain.
// Assumes d is asynchronous to clk.
`timescale 1ns/1ns
module rxcfg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: rtl/rxcfg_loader.sv
// Serial configuration loader and auto-poll sequencer of the receiver.
// Assumes the serial clock pin clocks the link side; clk is the core clock.
`timescale 1ns/1ns
module rxcfg_loader
  import rxcfg_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               sclk,
  input  wire logic               shutdown_pin,
  input  wire logic               data_in,
  input  wire logic               demod_bit,
  input  wire logic               demod_bit_ok,
  output logic                    data_out,
  output logic                    data_oe,
  output rxcfg_pkg::rxcfg_word_t  cfg_word,
  output logic                    auto_gain_fast,
  output logic                    watchdog_en,
  output logic                    poll_asleep,
  output logic [1:0]              slice_code,
  output logic [1:0]              bw_code,
  output logic [15:0]             window_us
);
  import rxcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the serial clock pin
  // Start and stop framings are data edges while sclk is high, so the data
  // pin itself clocks a small framing detector; sclk high is its qualifier.
  logic        sclk_high;
  logic        start_tgl_q, start_tgl_d;
  logic        seen_rise_q, seen_rise_d;
  logic        link_rst_n;
  assign sclk_high = sclk;

  // Rising data while sclk high: arms; falling after a rise: completes
  always_comb begin
    seen_rise_d = seen_rise_q;
    if (sclk_high) begin
      seen_rise_d = 1'b1;
    end
  end

  always_ff @(posedge data_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      seen_rise_q <= 1'b0;
    end else begin
      seen_rise_q <= seen_rise_d;
    end
  end

  // Data fall after a qualified rise marks a framing; core decides which
  always_comb begin
    start_tgl_d = start_tgl_q;
    if (sclk_high && seen_rise_q) begin
      start_tgl_d = ~start_tgl_q;
    end
  end

  always_ff @(negedge data_in or negedge resetn) begin
    if (!resetn) begin
      start_tgl_q <= 1'b0;
    end else begin
      start_tgl_q <= start_tgl_d;
    end
  end

  // Shift register on sclk rising edges, MSB first
  logic [`RXCFG_WORD_W-1:0] shift_q, shift_d;

  always_comb begin
    shift_d = {shift_q[`RXCFG_WORD_W-2:0], data_in};
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= '0;
    end else begin
      shift_q <= shift_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the core clock
  logic [2:0] sync_q;
  logic       frame_s, sclk_s, shutdown_pin_s;

  rxcfg_sync #(.W(3)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({start_tgl_q, sclk, shutdown_pin}),
    .q      (sync_q)
  );
  assign frame_s = sync_q[2];
  assign sclk_s  = sync_q[1];
  assign shutdown_pin_s  = sync_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Link state in the core domain
  rxcfg_link_e              link_q, link_d;
  logic                     frame_q;
  logic                     sclk_prev_q;
  logic [4:0]               bits_q, bits_d;
  logic [31:0]              idle_q, idle_d;
  rxcfg_word_t              word_q, word_d;
  rxcfg_word_t              snap_q, snap_d;
  logic                     oe_q, oe_d;
  logic                     frame_ev, rise_ev;

  assign frame_ev = frame_s ^ frame_q;
  assign rise_ev  = sclk_s & ~sclk_prev_q;
  // Sclk low disarms, so a data fall after a high last bit is no framing
  assign link_rst_n = resetn & sclk;

  // Framing, bit count, idle timeout and word update
  always_comb begin
    link_d = link_q;
    bits_d = bits_q;
    idle_d = idle_q;
    word_d = word_q;
    snap_d = snap_q;
    oe_d   = oe_q;
    if (link_q != RXCFG_IDLE) begin
      idle_d = rise_ev ? 32'h0000_0000 : idle_q + 32'h0000_0001;
    end
    // Sclk high hands the data pin to the host
    if (link_q == RXCFG_IDLE && sclk_s) begin
      oe_d = 1'b0;
    end else if (link_q == RXCFG_IDLE) begin
      oe_d = 1'b1;
    end
    unique case (link_q)
      RXCFG_IDLE: begin
        if (frame_ev) begin
          link_d = RXCFG_SHIFT;
          bits_d = 5'h00;
          idle_d = 32'h0000_0000;
          snap_d = word_q;
        end
      end
      RXCFG_ARMED: begin
        link_d = RXCFG_SHIFT;
      end
      RXCFG_SHIFT: begin
        if (rise_ev && bits_q != 5'h1F) begin
          bits_d = bits_q + 5'h01;
        end
        if (frame_ev) begin
          // Stop framing: low bits from the shifter, upper bits kept
          for (int i = 0; i < `RXCFG_WORD_W; i++) begin
            if (i < 32'(bits_q)) begin
              word_d[i] = shift_q[i];
            end else begin
              word_d[i] = snap_q[i];
            end
          end
          link_d = RXCFG_IDLE;
          oe_d   = 1'b1;
        end else if (idle_q >= `RXCFG_IDLE_CYCLES) begin
          link_d = RXCFG_IDLE;
          oe_d   = 1'b1;
        end
      end
      default: link_d = RXCFG_IDLE;
    endcase
    if (shutdown_pin_s) begin
      link_d = RXCFG_IDLE;
      oe_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_q      <= RXCFG_IDLE;
      frame_q     <= 1'b0;
      sclk_prev_q <= 1'b0;
      bits_q      <= '0;
      idle_q      <= '0;
      word_q      <= `RXCFG_RESET_WORD;
      snap_q      <= `RXCFG_RESET_WORD;
      oe_q        <= 1'b0;
    end else begin
      link_q      <= link_d;
      frame_q     <= frame_s;
      sclk_prev_q <= sclk_s;
      bits_q      <= bits_d;
      idle_q      <= idle_d;
      word_q      <= word_d;
      snap_q      <= snap_d;
      oe_q        <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings
  logic [2:0]  sleep_code;
  logic [2:0]  win_code;
  logic [1:0]  valid_code;
  logic [4:0]  need_bits;
  logic [15:0] win_d;
  assign sleep_code = word_q[`RXCFG_SLEEP_HI:`RXCFG_SLEEP_LO];
  assign win_code   = word_q[`RXCFG_WIN_HI:`RXCFG_WIN_LO];
  assign valid_code = word_q[`RXCFG_VALID_HI:`RXCFG_VALID_LO];

  // Valid-bit count: 0, 4, 8, 16
  always_comb begin
    unique case (valid_code)
      2'b00: need_bits = 5'd0;
      2'b01: need_bits = 5'd4;
      2'b10: need_bits = 5'd8;
      2'b11: need_bits = 5'd16;
    endcase
  end

  // Window at 433.92 MHz for the narrowest bandwidth, halved per bandwidth step
  always_comb begin
    logic [15:0] base;
    base = 16'h0000;
    unique case (win_code)
      3'b000: base = 16'd570;
      3'b001: base = 16'd532;
      3'b010: base = 16'd494;
      3'b011: base = 16'd457;
      3'b100: base = 16'd419;
      3'b101: base = 16'd381;
      3'b110: base = 16'd343;
      3'b111: base = 16'd305;
    endcase
    win_d = base >> word_q[`RXCFG_BW_HI:`RXCFG_BW_LO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-poll sequencer: sleep, check bits, then release data
  // Sleep period is 10 ms times two to the code; code 100 is 160 ms.
  rxcfg_poll_e poll_q, poll_d;
  logic [31:0] sleep_cnt_q, sleep_cnt_d;
  logic [4:0]  good_q, good_d;
  logic [1:0]  bad_q, bad_d;
  logic [31:0] sleep_len;
  logic        poll_en;
  assign sleep_len = 32'(`RXCFG_SLEEP_BASE_CY) << sleep_code;
  assign poll_en   = word_q[`RXCFG_BIT_POLL];

  always_comb begin
    poll_d      = poll_q;
    sleep_cnt_d = sleep_cnt_q;
    good_d      = good_q;
    bad_d       = bad_q;
    unique case (poll_q)
      RXCFG_AWAKE: begin
        if (poll_en && link_q == RXCFG_IDLE && frame_ev == 1'b0) begin
          poll_d      = RXCFG_SLEEP;
          sleep_cnt_d = 32'h0000_0000;
        end
      end
      RXCFG_SLEEP: begin
        sleep_cnt_d = sleep_cnt_q + 32'h0000_0001;
        if (sleep_cnt_q >= sleep_len - 32'h0000_0001) begin
          poll_d = RXCFG_CHECK;
          good_d = 5'd0;
          bad_d  = 2'd0;
        end
      end
      RXCFG_CHECK: begin
        if (good_q >= need_bits) begin
          poll_d = RXCFG_RUN;
        end else if (demod_bit_ok) begin
          good_d = good_q + 5'd1;
          bad_d  = 2'd0;
        end else if (demod_bit) begin
          good_d = 5'd0;
          bad_d  = bad_q + 2'd1;
          if (bad_q == 2'd3) begin
            poll_d      = RXCFG_SLEEP;
            sleep_cnt_d = 32'h0000_0000;
          end
        end
      end
      RXCFG_RUN: begin
        poll_d = RXCFG_RUN;
      end
    endcase
    // A fresh load restarts the sequencer
    if (frame_ev || shutdown_pin_s || !poll_en) begin
      poll_d = RXCFG_AWAKE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      poll_q      <= RXCFG_AWAKE;
      sleep_cnt_q <= '0;
      good_q      <= '0;
      bad_q       <= '0;
    end else begin
      poll_q      <= poll_d;
      sleep_cnt_q <= sleep_cnt_d;
      good_q      <= good_d;
      bad_q       <= bad_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_out       <= 1'b0;
      data_oe        <= 1'b0;
      cfg_word       <= `RXCFG_RESET_WORD;
      auto_gain_fast <= 1'b1; // Matches the power-on word
      watchdog_en    <= 1'b0;
      poll_asleep    <= 1'b0;
      slice_code     <= 2'b11;
      bw_code        <= 2'b11;
      window_us      <= 16'h0000;
    end else begin
      // Data held low while sleeping or checking
      data_out       <= (poll_q == RXCFG_AWAKE || poll_q == RXCFG_RUN) && !shutdown_pin_s
                        ? demod_bit : 1'b0;
      data_oe        <= oe_d;
      cfg_word       <= word_q;
      auto_gain_fast <= ~word_q[`RXCFG_BIT_AGC_FAST];
      watchdog_en    <= ~word_q[`RXCFG_BIT_WDOG_OFF];
      poll_asleep    <= (poll_q == RXCFG_SLEEP);
      slice_code     <= word_q[`RXCFG_SLICE_HI:`RXCFG_SLICE_LO];
      bw_code        <= word_q[`RXCFG_BW_HI:`RXCFG_BW_LO];
      window_us      <= win_d;
    end
  end
endmodule

// file: bench/rxcfg_loader_sva.sv
// Port checker for the configuration loader.
// Assumes it is bound to rxcfg_loader; sclk is only sampled on clk.
`timescale 1ns/1ns
module rxcfg_loader_sva (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   sclk,
  input wire logic                   shutdown_pin,
  input wire logic                   data_out,
  input wire logic                   data_oe,
  input wire rxcfg_pkg::rxcfg_word_t cfg_word,
  input wire logic                   auto_gain_fast,
  input wire logic                   watchdog_en,
  input wire logic                   poll_asleep,
  input wire logic [1:0]             slice_code,
  input wire logic [1:0]             bw_code,
  input wire logic [15:0]            window_us
);
  import rxcfg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // Decoded outputs follow a settled word, registered in the same stage as cfg_word
  agc_fast_a: assert property (
    $stable(cfg_word)[*2] |-> auto_gain_fast == !cfg_word[19]) else $error("gain flag wrong");
  wdog_off_a: assert property (
    $stable(cfg_word)[*2] |-> watchdog_en == !cfg_word[18]) else $error("watchdog flag wrong");
  slice_copy_a: assert property (
    $stable(cfg_word)[*2] |-> slice_code == cfg_word[6:5]) else $error("slice code wrong");
  bw_copy_a: assert property (
    $stable(cfg_word)[*2] |-> bw_code == cfg_word[4:3]) else $error("bandwidth code wrong");
  window_457_a: assert property (
    $stable(cfg_word)[*3] ##0 (cfg_word[11:9] == 3'b011 && cfg_word[4:3] == 2'b00)
    |-> window_us == 16'd457) else $error("window time wrong");
  ////////////////////////////////////////////////////////////////
  // Pin ownership, shutdown and word update timing
  shut_idle_a: assert property (
    shutdown_pin[*6] |-> !data_oe) else $error("pin driven in shutdown");
  sclk_tri_a: assert property (
    $rose(sclk) && data_oe |-> ##[1:6] !data_oe) else $error("pin not released");
  apply_stop_a: assert property (
    $changed(cfg_word) |-> !$past(data_oe, 2)) else $error("word changed outside frame");
  ////////////////////////////////////////////////////////////////
  // Polling: no sleep without the poll bit, no data while asleep
  poll_off_a: assert property (
    (!cfg_word[15])[*3] |-> !poll_asleep) else $error("sleeping with poll off");
  data_withhold_a: assert property (
    poll_asleep && $past(poll_asleep) |-> !data_out) else $error("data leaked in sleep");
endmodule

bind rxcfg_loader rxcfg_loader_sva chk (.clk(clk), .resetn(resetn), .sclk(sclk),
  .shutdown_pin(shutdown_pin), .data_out(data_out), .data_oe(data_oe), .cfg_word(cfg_word),
  .auto_gain_fast(auto_gain_fast), .watchdog_en(watchdog_en), .poll_asleep(poll_asleep),
  .slice_code(slice_code), .bw_code(bw_code), .window_us(window_us));

// file: bench/rxcfg_host_model.sv
// Host side model: frames and shifts one word per go request.
// Assumes lclk is the link clock and go stays high until busy rises.
`timescale 1ns/1ns
module rxcfg_host_model (
  input  wire logic        lclk,
  input  wire logic        go,
  input  wire logic [19:0] word,
  input  wire logic [4:0]  nbits,
  input  wire logic [31:0] hold,
  output logic             sclk,
  output logic             host_oe,
  output logic             host_d,
  output logic             busy
);
  // Two link cycles a step keep edges six core cycles apart
  task automatic step(input logic s, input logic d);
    repeat (2) @(posedge lclk);
    sclk   <= s;
    host_d <= d;
  endtask
  ////////////////////////////////////////////////////////////////
  // Serial clock stands low between frames
  initial begin
    sclk    = 1'b0;
    host_oe = 1'b0;
    host_d  = 1'b0;
    busy    = 1'b0;
    forever begin
      @(posedge lclk);
      if (go && !busy) begin
        busy    <= 1'b1;
        host_oe <= 1'b1;
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        for (int i = int'(nbits) - 1; i >= 0; i--) begin
          // Data moves only while sclk stays low, never with an sclk edge
          step(1'b0, host_d);
          step(1'b0, word[i]);
          step(1'b1, word[i]);
          if (i == int'(nbits) - 1) repeat (hold) @(posedge lclk);
        end
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        host_oe <= 1'b0;
        busy    <= 1'b0;
      end
    end
  end
endmodule

// file: bench/test_rx_serial_config_loader.sv
// Self-checking bench for the receiver configuration loader.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ns
module test_rx_serial_config_loader;
  import rxcfg_pkg::*;
  logic        clk, lclk, resetn, shutdown_pin, demod_bit, demod_bit_ok, dm_en, flip, pin;
  logic        go, sclk, host_oe, host_d, busy, data_out, data_oe;
  logic        auto_gain_fast, watchdog_en, poll_asleep;
  logic [1:0]  slice_code, bw_code;
  logic [15:0] window_us;
  logic [4:0]  nbits;
  logic [19:0] word, exp_w;
  logic [31:0] hold, lf, rw;
  rxcfg_word_t cfg_word;
  int          miscompares, n_checks, cyc, hi;
  // Pin level: device wins, else host, else a changing pattern
  assign pin = data_oe ? data_out : (host_oe ? host_d : flip);
  rxcfg_loader dut (.clk(clk), .resetn(resetn), .sclk(sclk), .shutdown_pin(shutdown_pin),
    .data_in(pin), .demod_bit(demod_bit), .demod_bit_ok(demod_bit_ok), .data_out(data_out),
    .data_oe(data_oe), .cfg_word(cfg_word), .auto_gain_fast(auto_gain_fast),
    .watchdog_en(watchdog_en), .poll_asleep(poll_asleep), .slice_code(slice_code),
    .bw_code(bw_code), .window_us(window_us));
  rxcfg_host_model host (.lclk(lclk), .go(go), .word(word), .nbits(nbits), .hold(hold),
    .sclk(sclk), .host_oe(host_oe), .host_d(host_d), .busy(busy));
  ////////////////////////////////////////////////////////////////
  // Clocks: core 4 ns, link 12 ns offset
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #5;
    forever #6 lclk = ~lclk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Low n bits are replaced, upper bits kept
  function automatic logic [19:0] merge(input logic [19:0] old, w, input logic [4:0] n);
    logic [19:0] m;
    m = (20'h0_0001 << n) - 20'h0_0001;
    return (old & ~m) | (w & m);
  endfunction
  task automatic check(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 60000 && busy !== v; k++) @(posedge clk);
  endtask
  task automatic load(input logic [19:0] w, input logic [4:0] n, input logic [31:0] h);
    word  <= w;
    nbits <= n;
    hold  <= h;
    go    <= 1'b1;
    wait_busy(1'b1);
    go <= 1'b0;
    wait_busy(1'b0);
    repeat (20) @(posedge clk);
  endtask
  // Counts data pin highs while random bits arrive
  task automatic watch(output int h);
    h = 0;
    dm_en <= 1'b1;
    repeat (200) begin // Burst far shorter than a sleep
      @(posedge clk);
      h += int'(data_out === 1'b1);
    end
    dm_en <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Demodulator stimulus, pattern and hang limit
  always @(posedge clk) begin
    flip         <= ~flip;
    lf           <= lfsr_next(lf);
    demod_bit    <= dm_en & lf[0];
    demod_bit_ok <= dm_en & lf[1];
    cyc          <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn, go, shutdown_pin, dm_en, flip, demod_bit, demod_bit_ok} = 7'h00;
    {word, nbits, hold, miscompares, n_checks, cyc} = '0;
    lf = 32'h0000_0a2c;
    rw = 32'h0000_0a2c;
    repeat (20) @(posedge clk);
    check(cfg_word, 20'h4_2_E_7_8);
    check({slice_code, bw_code}, 4'hF);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    check(window_us, 16'd38);
    check(data_oe, 1'b1);
    watch(hi);
    check(hi > 0, 1'b1);
    exp_w = 20'h4_C_7_6_0;
    load(exp_w, 5'd20, 32'h0);
    check(cfg_word, exp_w);
    check({auto_gain_fast, watchdog_en, slice_code, bw_code}, 6'b10_1100);
    check(window_us, 16'd457);
    check(poll_asleep, 1'b1);
    watch(hi);
    check(hi, 0);
    load(20'h0_0006, 5'd3, 32'h0);
    exp_w = merge(exp_w, 20'h0_0006, 5'd3);
    check(cfg_word, exp_w);
    for (int k = 0; k < 8; k++) begin
      rw = lfsr_next(rw);
      nbits = (k == 0) ? 5'd20 : (k == 1) ? 5'd1 : 5'(rw[24:20] % 5'd20 + 5'd1);
      load(rw[19:0], nbits, 32'h0);
      exp_w = merge(exp_w, rw[19:0], nbits);
      check(cfg_word, exp_w);
    end
    shutdown_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check(data_oe, 1'b0);
    shutdown_pin <= 1'b0;
    repeat (10) @(posedge clk);
    check({data_oe, cfg_word}, {1'b1, exp_w});
    load(20'h0_0000, 5'd20, 32'd17000);
    check(cfg_word, exp_w);
    summarize();
  end
endmodule
